// ### dv/sfsl_host.sv
// host model: status reads and sample pops on the register side
`timescale 1ns/1ps

module sfsl_host (
    input  wire logic  mclk,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic       pop_req
);
    initial
    begin
        reg_rd   = 1'b0;
        reg_addr = 8'h00;
        pop_req  = 1'b0;
    end

    // read only: the host never writes the status byte
    task automatic read_reg(input logic [7:0] addr);
        @(negedge mclk);
        reg_rd   = 1'b1;
        reg_addr = addr;
        @(negedge mclk);
        reg_rd   = 1'b0;
        // released address must not look like a held one
        reg_addr = ~addr;
    endtask : read_reg

    task automatic pop_one();
        @(negedge mclk);
        pop_req = 1'b1;
        @(negedge mclk);
        pop_req = 1'b0;
    endtask : pop_one
endmodule : sfsl_host

// ### dv/tb_top.sv
// self-checking bench for the sample fifo status block
`timescale 1ns/1ps

module tb_top;
    logic                          mclk;
    logic                          rst_b;
    sfsl_pkg::sfsl_cfg_t           cfg;
    logic                          smp_valid;
    logic                          smp_ready;
    logic [sfsl_pkg::SAMPLE_W-1:0] smp_data;
    logic                          pop_req;
    logic                          pop_valid;
    logic [sfsl_pkg::SAMPLE_W-1:0] pop_data;
    logic                          reg_rd;
    logic [7:0]                    reg_addr;
    logic [7:0]                    reg_rdata;
    logic                          rd_seen;
    logic                          ovf;
    logic [31:0]                   seed;
    int                            num_errors;
    int                            checks;
    int                            cnt;
    logic [7:0]                    st_q[$];
    logic [sfsl_pkg::SAMPLE_W-1:0] dat_q[$];
    logic [1:0]                    sz[5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
    logic [2:0]                    en[5] = '{3'h6, 3'h7, 3'h6, 3'h7, 3'h4};

    sfsl_top dut (
        .mclk(mclk), .rst_b(rst_b), .cfg(cfg), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .pop_req(pop_req),
        .pop_valid(pop_valid), .pop_data(pop_data), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata)
    );
    sfsl_host host (
        .mclk(mclk), .reg_rd(reg_rd), .reg_addr(reg_addr), .pop_req(pop_req)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic close_out();
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic cmp(input logic [47:0] e, input logic [47:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t exp %0h got %0h", $time, e, g);
        end
    endtask : cmp

    task automatic push(input int cap);
        logic [31:0] r;
        int          n;
        r = xs();
        @(negedge mclk);
        smp_valid = 1'b1;
        smp_data  = {r, r[31:16] ^ r[15:0]};
        for (n = 0; n < 50 && smp_ready !== 1'b1; n++)
            @(negedge mclk);
        if (n == 50)
        begin
            num_errors++;
            close_out();
        end
        @(posedge mclk);
        // fifo mode drops when full, stream drops the oldest
        if (cnt < cap)
        begin
            dat_q.push_back(smp_data);
            cnt++;
        end
        else
        begin
            ovf = 1'b1;
            if (cfg.mode == sfsl_pkg::SFSL_MODE_STREAM)
            begin
                void'(dat_q.pop_front());
                dat_q.push_back(smp_data);
            end
        end
        @(negedge mclk);
        smp_valid = 1'b0;
    endtask : push

    task automatic chk(input int sh, input int th);
        sfsl_pkg::sfsl_status_t s;
        // store drain plus one cycle of status lag
        repeat (4) @(negedge mclk);
        s.resv      = 1'b0;
        s.wtm_hit   = (cnt >= th) && (cnt != 0);
        s.overflow  = ovf;
        s.not_empty = (cnt != 0);
        s.level     = 4'(cnt >> sh);
        st_q.push_back(s);
        host.read_reg(sfsl_pkg::FIFO_STATE_REG_ADDR);
    endtask : chk

    task automatic pop();
        host.pop_one();
        cnt--;
    endtask : pop

    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
            rd_seen <= 1'b0;
        else
            rd_seen <= reg_rd;

    always @(negedge mclk)
    begin
        if (rd_seen === 1'b1)
            cmp({40'h0, st_q.pop_front()}, {40'h0, reg_rdata});
        if (pop_valid === 1'b1)
            cmp(dat_q.pop_front(), pop_data);
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        close_out();
    end

    initial
    begin
        int i;
        int w;
        int n;
        int cap;
        rst_b     = 1'b0;
        cfg       = '0;
        smp_valid = 1'b0;
        smp_data  = '0;
        seed      = 32'h0001_4996;
        ovf       = 1'b0;
        cnt       = 0;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        chk(1, 4);
        st_q.push_back(8'h00);
        host.read_reg(8'h14);
        cfg.mode   = sfsl_pkg::SFSL_MODE_FIFO;
        cfg.wtm    = sfsl_pkg::SFSL_WTM_QUARTER;
        cfg.acc_en = 1'b1;
        // every level step, the quarter mark, full and two drops
        for (i = 0; i < 18; i++)
        begin
            push(16);
            chk(1, 4);
        end
        for (i = 0; i < 16; i++)
        begin
            pop();
            if (i == 7)
                chk(1, 4);
        end
        ovf = 1'b0;
        chk(1, 4);
        cfg.mode   = sfsl_pkg::SFSL_MODE_STREAM;
        cfg.size   = 2'h1;
        cfg.gyr_en = 1'b1;
        repeat (20) push(64);
        for (i = 0; i < 5; i++)
            for (w = 1; w < 4; w++)
            begin
                cfg.size = sz[i];
                {cfg.acc_en, cfg.gyr_en, cfg.mag_en} = en[i];
                cfg.wtm = sfsl_pkg::sfsl_wtm_t'(w);
                n   = $countones(en[i]);
                cap = (16 << sz[i]) * n;
                chk(1 + sz[i] + (n >= 2), cap * w / 4);
            end
        repeat (20) pop();
        chk(1, 4);
        // single sensor, depth 16: two evictions of the oldest
        cfg.size = 2'h0;
        repeat (18) push(16);
        chk(1, 12);
        repeat (16) pop();
        ovf = 1'b0;
        chk(1, 12);
        // unused mode behaves as bypass: sample discarded, no overflow
        cfg.mode = sfsl_pkg::SFSL_MODE_UNUSED;
        push(0);
        ovf = 1'b0;
        chk(1, 12);
        close_out();
    end
endmodule : tb_top

// ### logic/sfsl_pkg.sv
// sample fifo status package: register map, config and status layouts
package sfsl_pkg;
    localparam logic [7:0] FIFO_STATE_REG_ADDR = 8'h15;
    localparam int         SAMPLE_BYTES        = 6;
    localparam int         AXIS_BYTES          = 2;
    localparam int         SAMPLE_W            = SAMPLE_BYTES * 8;
    localparam int         MEM_DEPTH           = 256;
    localparam int         PTR_W               = 8;
    localparam int         CNT_W               = 10;
    localparam int         NUM_SENSORS         = 3;
    localparam int         BUF_DEPTH           = 8;
    localparam logic [CNT_W-1:0] BASE_DEPTH    = 10'h010;
    localparam logic [2:0] GRAN_BASE_SHIFT     = 3'h1;
    localparam logic [3:0] LEVEL_MAX           = 4'hf;
    localparam logic [1:0] SIZE_MAX_CODE       = 2'h3;
    localparam logic [1:0] SIZE_3SENS_CODE     = 2'h2;

    typedef enum logic [1:0] {
        SFSL_MODE_BYPASS = 2'h0,
        SFSL_MODE_FIFO   = 2'h1,
        SFSL_MODE_STREAM = 2'h2,
        SFSL_MODE_UNUSED = 2'h3
    } sfsl_mode_t;

    typedef enum logic [1:0] {
        SFSL_WTM_OFF     = 2'h0,
        SFSL_WTM_QUARTER = 2'h1,
        SFSL_WTM_HALF    = 2'h2,
        SFSL_WTM_3QUART  = 2'h3
    } sfsl_wtm_t;

    typedef struct packed {
        sfsl_mode_t mode;
        logic [1:0] size;
        sfsl_wtm_t  wtm;
        logic       acc_en;
        logic       gyr_en;
        logic       mag_en;
    } sfsl_cfg_t;

    typedef struct packed {
        logic       resv;
        logic       wtm_hit;
        logic       overflow;
        logic       not_empty;
        logic [3:0] level;
    } sfsl_status_t;

    localparam sfsl_status_t STATUS_RESET = 8'h00;
endpackage : sfsl_pkg

// ### logic/sfsl_top.sv
// sample fifo with status register: ingress buffer, store, status flags
//
// Function
// - 8-bit status: reserved, watermark, overflow, non-empty
// - fill level in bits 3:0, coarse
// - level step follows depth code, doubled for two or more sensors
// - capacity is depth times enabled sensors
// - each sample is six bytes, two per axis
// - smallest single-sensor depth steps by two samples
// - depth codes 16/32/64/128, 128 two sensors max
// - watermark at quarter, half, three quarters
// - fifo mode stops when full; stream drops oldest
`timescale 1ns/1ps

module sfsl_buf #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   n_q, n_d;
    logic          push, pop;

    assign in_ready  = (n_q != (AW+1)'(D));
    assign out_valid = (n_q != '0);
    assign out_data  = mem[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wp_d = push ? AW'((wp_q + 1'b1) % D) : wp_q;
        rp_d = pop ? AW'((rp_q + 1'b1) % D) : rp_q;
        n_d  = n_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_q <= '0;
            rp_q <= '0;
            n_q  <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            n_q  <= n_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end
endmodule : sfsl_buf

module sfsl_top #(
    parameter int MEM_DEPTH = sfsl_pkg::MEM_DEPTH
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    input  wire sfsl_pkg::sfsl_cfg_t           cfg,
    input  wire logic                          smp_valid,
    output logic                               smp_ready,
    input  wire logic [sfsl_pkg::SAMPLE_W-1:0] smp_data,
    input  wire logic                          pop_req,
    output logic                               pop_valid,
    output logic [sfsl_pkg::SAMPLE_W-1:0]      pop_data,
    input  wire logic                          reg_rd,
    input  wire logic [7:0]                    reg_addr,
    output logic [7:0]                         reg_rdata
);
    localparam int PW = sfsl_pkg::PTR_W;
    localparam int CW = sfsl_pkg::CNT_W;

    logic [sfsl_pkg::SAMPLE_W-1:0] mem [MEM_DEPTH];
    logic                          b_valid, b_ready;
    logic [sfsl_pkg::SAMPLE_W-1:0] b_data;

    // ingress buffer; drain stalls when the host pops, one port per cycle
    sfsl_buf #(
        .W (sfsl_pkg::SAMPLE_W),
        .D (sfsl_pkg::BUF_DEPTH)
    ) u_buf (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .in_data   (smp_data),
        .out_valid (b_valid),
        .out_ready (b_ready),
        .out_data  (b_data)
    );

    // capacity and granularity
    logic [1:0]    n_sens;
    logic [1:0]    size_eff;
    logic [CW-1:0] depth, cap;
    logic [2:0]    gshift;

    always_comb
    begin
        n_sens = 2'(cfg.acc_en) + 2'(cfg.gyr_en) + 2'(cfg.mag_en);
        size_eff = cfg.size;
        // largest depth is illegal with three sensors; clamp it
        if (n_sens == 2'(sfsl_pkg::NUM_SENSORS)
            && cfg.size == sfsl_pkg::SIZE_MAX_CODE)
            size_eff = sfsl_pkg::SIZE_3SENS_CODE;
        depth  = sfsl_pkg::BASE_DEPTH << size_eff;
        cap    = CW'(depth * n_sens);
        gshift = sfsl_pkg::GRAN_BASE_SHIFT + 3'(size_eff)
               + 3'(n_sens > 2'h1);
    end

    // store state
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          stop_q, stop_d, ovf_q, ovf_d;
    logic          pv_q, pv_d;
    logic          bypass, full, do_pop, do_push, drop, evict;

    assign bypass = (cfg.mode == sfsl_pkg::SFSL_MODE_BYPASS)
                 || (cfg.mode == sfsl_pkg::SFSL_MODE_UNUSED);
    assign full    = (cnt_q >= cap);
    assign do_pop  = pop_req && (cnt_q != '0) && !bypass;
    assign b_ready = !do_pop;
    assign evict   = b_valid && b_ready && !bypass && full
                  && (cfg.mode == sfsl_pkg::SFSL_MODE_STREAM);
    assign drop    = b_valid && b_ready && !bypass && !evict
                  && (full || stop_q);
    assign do_push = b_valid && b_ready && !bypass && !drop;

    always_comb
    begin
        wp_d   = do_push ? PW'(wp_q + 1'b1) : wp_q;
        rp_d   = (do_pop || evict) ? PW'(rp_q + 1'b1) : rp_q;
        cnt_d  = cnt_q + CW'(do_push && !evict) - CW'(do_pop);
        stop_d = stop_q;
        ovf_d  = ovf_q;
        pv_d   = do_pop;
        if (bypass)
        begin
            wp_d   = '0;
            rp_d   = '0;
            cnt_d  = '0;
            stop_d = 1'b0;
        end
        else
        begin
            // restart only after the host empties it
            if (cnt_d == '0)
            begin
                stop_d = 1'b0;
                ovf_d  = 1'b0;
            end
            if (cfg.mode == sfsl_pkg::SFSL_MODE_FIFO && cnt_d >= cap)
                stop_d = 1'b1;
            // a stale stop must not block a circular buffer
            else if (cfg.mode != sfsl_pkg::SFSL_MODE_FIFO)
                stop_d = 1'b0;
            // set beats clear in the same cycle
            if (drop || evict)
                ovf_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_q   <= '0;
            rp_q   <= '0;
            cnt_q  <= '0;
            stop_q <= 1'b0;
            ovf_q  <= 1'b0;
            pv_q   <= 1'b0;
        end
        else
        begin
            wp_q   <= wp_d;
            rp_q   <= rp_d;
            cnt_q  <= cnt_d;
            stop_q <= stop_d;
            ovf_q  <= ovf_d;
            pv_q   <= pv_d;
        end
    end

    // six bytes per entry, axis words kept whole
    always_ff @(posedge mclk)
    begin
        if (do_push)
            mem[wp_q] <= b_data;
        if (do_pop)
            pop_data <= mem[rp_q];
    end
    assign pop_valid = pv_q;

    // status register
    sfsl_pkg::sfsl_status_t st_q, st_d;
    logic [CW-1:0]          lvl, thr;
    logic [7:0]             rd_q, rd_d;

    always_comb
    begin
        lvl = cnt_q >> gshift;
        case (cfg.wtm)
            sfsl_pkg::SFSL_WTM_QUARTER: thr = cap >> 2;
            sfsl_pkg::SFSL_WTM_HALF:    thr = cap >> 1;
            sfsl_pkg::SFSL_WTM_3QUART:  thr = (cap >> 1) + (cap >> 2);
            default:                    thr = '0;
        endcase
        st_d.resv      = 1'b0;
        st_d.wtm_hit   = (cfg.wtm != sfsl_pkg::SFSL_WTM_OFF)
                      && (cnt_q != '0) && (cnt_q >= thr);
        st_d.overflow  = ovf_q;
        st_d.not_empty = (cnt_q != '0);
        st_d.level     = (lvl > CW'(sfsl_pkg::LEVEL_MAX))
                       ? sfsl_pkg::LEVEL_MAX : lvl[3:0];
        // read-only: no write path exists
        rd_d = (reg_rd && reg_addr == sfsl_pkg::FIFO_STATE_REG_ADDR)
             ? st_q : 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= sfsl_pkg::STATUS_RESET;
            rd_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            rd_q <= rd_d;
        end
    end
    assign reg_rdata = rd_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_RESV_ZERO: assert property (!st_q.resv)
        else $error("reserved status bit set");
    AST_NONEMPTY: assert property (
        st_q.not_empty == ($past(cnt_q) != '0))
        else $error("not_empty disagrees with count");
    AST_LEVEL: assert property (
        ##1 st_q.level == ((($past(cnt_q) >> $past(gshift))
        > CW'(sfsl_pkg::LEVEL_MAX)) ? sfsl_pkg::LEVEL_MAX
        : 4'($past(cnt_q) >> $past(gshift))))
        else $error("level not count over granularity");
    AST_CAP: assert property (
        cap == (cfg.acc_en ? depth : '0) + (cfg.gyr_en ? depth : '0)
        + (cfg.mag_en ? depth : '0))
        else $error("capacity not sum of enabled depths");
    AST_GRAN16: assert property (
        (n_sens == 2'h1 && size_eff == 2'h0)
        |-> (cap == 10'h010 && gshift == 3'h1))
        else $error("smallest capacity or step wrong");
    AST_DEPTH3: assert property (
        (n_sens == 2'h3) |-> (depth <= 10'h040))
        else $error("depth 128 with three sensors");
    AST_NEVER_OVER: assert property (
        (!bypass && cnt_q <= cap) |=> (cnt_q <= $past(cap)))
        else $error("count exceeds capacity");
    AST_STOPPED: assert property (
        (stop_q && cfg.mode == sfsl_pkg::SFSL_MODE_FIFO && b_valid
        && !do_pop) |-> drop)
        else $error("sample accepted while stopped");
    AST_WTM: assert property (
        (cfg.wtm == sfsl_pkg::SFSL_WTM_OFF) |=> !st_q.wtm_hit)
        else $error("watermark with code 00");
    AST_RDATA: assert property (
        (reg_rd && reg_addr == sfsl_pkg::FIFO_STATE_REG_ADDR)
        |=> reg_rdata == $past(st_q))
        else $error("status read returns wrong value");
    AST_ENTRY_W: assert property (
        do_push |=> mem[$past(wp_q)] == $past(b_data))
        else $error("stored entry differs from sample");
endmodule : sfsl_top
